// *** common/rpdo_pkg.sv ***
// Package of constants and types for the regulator power-down order block.
package rpdo_pkg;

  // ****************************************************************
  // Outputs and field layout
  // ****************************************************************
  localparam int NUM_OUT = 7;
  localparam int ORDER_W = 3;
  localparam logic [ORDER_W-1:0] ORDER_RESET = 3'h0;
  localparam int IDX_BUCK_ONE = 0;
  localparam int IDX_BUCK_TWO = 1;
  localparam int IDX_BUCK_THREE = 2;
  localparam int IDX_LINEAR_ONE = 3;
  localparam int IDX_LINEAR_TWO = 4;
  localparam int IDX_LINEAR_THREE = 5;
  localparam int IDX_MEMREF = 6;

  // ****************************************************************
  // Register map (byte addresses are four times the index)
  // ****************************************************************
  localparam logic [7:0] REG_BUCK_ONE_OFF_ORDER = 8'h5F;
  localparam logic [7:0] REG_BUCK_TWO_OFF_ORDER = 8'h60;
  localparam logic [7:0] REG_BUCK_THREE_OFF_ORDER = 8'h61;
  localparam logic [7:0] REG_LINEAR_ONE_OFF_ORDER = 8'h62;
  localparam logic [7:0] REG_LINEAR_TWO_OFF_ORDER = 8'h63;
  localparam logic [7:0] REG_LINEAR_THREE_OFF_ORDER = 8'h64;
  localparam logic [7:0] REG_MEMREF_OFF_ORDER = 8'h65;
  localparam logic [7:0] REG_CTRL = 8'h70;
  localparam logic [7:0] REG_STATUS = 8'h71;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RESTORE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_EN_LSB = 8;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  localparam int STEP_CYCLES = 4;

  typedef enum logic [1:0] {
    RPDO_IDLE,
    RPDO_STEP,
    RPDO_WAIT,
    RPDO_DONE
  } rpdo_state_t;

endpackage

// *** hdl/rpdo_step_select.sv ***
// Picks the highest pending order value and the outputs that hold it.
`timescale 1ns/1ps
module rpdo_step_select #(
  parameter int N = 7,
  parameter int W = 3
) (
  input wire logic [N*W-1:0] i_order,
  input wire logic [N-1:0] i_pending,
  output logic [W-1:0] o_top,
  output logic [N-1:0] o_hit
);

  always_comb begin
    o_top = '0;
    for (int i = 0; i < N; i++) begin
      if (i_pending[i] && i_order[i*W +: W] > o_top) begin
        o_top = i_order[i*W +: W];
      end
    end
  end

  // Equal values go off in the same step.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      o_hit[i] = i_pending[i] && (i_order[i*W +: W] == o_top);
    end
  end

endmodule

// *** hdl/rpdo_top.sv ***
// Power-down order registers and the power-down sequencer, APB slave.
//
// Contract
// - One 3-bit off order per regulator output
// - Fields start from fused power-up order (reset loads zero here; fused copy is taken only on a restore)
// - Switch off from highest order to lowest
// - All fields zero: all off at once
// - Host rewrites fields; next power-down uses them
// - Power-up order never changed by writes
`timescale 1ns/1ps
module rpdo_top #(
  parameter int STEP_CYCLES = rpdo_pkg::STEP_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [rpdo_pkg::NUM_OUT*rpdo_pkg::ORDER_W-1:0] i_fused_on_order,
  input wire logic i_load_fused,
  input wire logic i_power_down,
  output logic [rpdo_pkg::NUM_OUT*rpdo_pkg::ORDER_W-1:0] o_on_order,
  output logic [rpdo_pkg::NUM_OUT-1:0] o_out_enable,
  output logic o_busy,
  output logic o_done
);

  localparam int N = rpdo_pkg::NUM_OUT;
  localparam int W = rpdo_pkg::ORDER_W;

  // ****************************************************************
  // Register access
  // ****************************************************************
  logic [N*W-1:0] order_q;
  logic [N-1:0] en_q;
  logic [N-1:0] hit;
  // The step counter must reach STEP_CYCLES; the parameter must be 1 or more.
  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  logic [CNT_W-1:0] cnt_q;
  rpdo_pkg::rpdo_state_t state_q;
  logic access;
  logic wr;
  logic ctrl_wr;
  logic restore;
  logic setup;
  logic [7:0] idx;
  logic [N-1:0] field_wr;
  logic [31:0] rdata_d;
  logic rerr_d;

  assign access = i_psel && i_penable;
  assign wr = access && i_pwrite;
  assign setup = i_psel && !i_penable;
  assign idx = i_paddr[9:2];
  assign ctrl_wr = wr && idx == rpdo_pkg::REG_CTRL;
  // Every register answers at once, so the access phase never stretches.
  assign o_pready = 1'b1;

  function automatic logic [3:0] field_of(input logic [7:0] ix);
    if (ix >= rpdo_pkg::REG_BUCK_ONE_OFF_ORDER &&
        ix <= rpdo_pkg::REG_MEMREF_OFF_ORDER) begin
      field_of = 4'(ix - rpdo_pkg::REG_BUCK_ONE_OFF_ORDER);
    end else begin
      field_of = 4'hF;
    end
  endfunction

  function automatic logic mapped(input logic [7:0] ix);
    mapped = (field_of(ix) != 4'hF) || ix == rpdo_pkg::REG_CTRL ||
             ix == rpdo_pkg::REG_STATUS;
  endfunction

  // Fused power-up order is passed through untouched; no write path exists.
  assign o_on_order = i_fused_on_order;

  // The fused copy may be taken again at any time, from the pin or CTRL.
  assign restore = i_load_fused ||
                   (ctrl_wr && i_pwdata[rpdo_pkg::CTRL_RESTORE_BIT]);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      field_wr[i] = wr && field_of(idx) == 4'(i) && i_paddr[1:0] == 2'h0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_field
      always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
          order_q[g*W +: W] <= rpdo_pkg::ORDER_RESET;
        end else if (restore) begin
          order_q[g*W +: W] <= i_fused_on_order[g*W +: W];
        end else if (field_wr[g]) begin
          // Taken in any state; the running sequence keeps its snapshot.
          order_q[g*W +: W] <= i_pwdata[W-1:0];
        end
      end
    end
  endgenerate

  // Read data is chosen in the setup cycle and held in a register through
  // the access phase, so the bus never sees a field change mid-transfer.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (field_of(idx) != 4'hF) begin
      rdata_d[W-1:0] = order_q[field_of(idx)*W +: W];
    end else if (idx == rpdo_pkg::REG_STATUS) begin
      rdata_d[rpdo_pkg::STAT_BUSY_BIT] = o_busy;
      rdata_d[rpdo_pkg::STAT_DONE_BIT] = o_done;
      rdata_d[rpdo_pkg::STAT_EN_LSB +: N] = en_q;
    end
  end

  assign rerr_d = !mapped(idx) || i_paddr[1:0] != 2'h0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_prdata <= rdata_d;
    end else begin
      o_prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pslverr <= rerr_d;
    end else begin
      o_pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic [N*W-1:0] snap_q;
  logic [N*W-1:0] snap_d;
  logic [N-1:0] en_d;
  logic [N-1:0] left;
  logic [CNT_W-1:0] cnt_d;
  rpdo_pkg::rpdo_state_t state_d;
  logic start;
  logic gap_end;

  // A start that arrives while busy or done is dropped by the state machine.
  assign start = i_power_down ||
                 (ctrl_wr && i_pwdata[rpdo_pkg::CTRL_START_BIT]);

  rpdo_step_select #(
    .N(N),
    .W(W)
  ) u_sel (
    .i_order(snap_q),
    .i_pending(en_q),
    .o_top(),
    .o_hit(hit)
  );

  // Outputs still on once the current top group is switched off.
  assign left = en_q & ~hit;
  assign gap_end = cnt_q == CNT_W'(STEP_CYCLES - 1);

  // Next state of the sequencer; the registers below only take it.
  always_comb begin
    state_d = state_q;
    en_d = en_q;
    snap_d = snap_q;
    cnt_d = cnt_q;
    unique case (state_q)
      rpdo_pkg::RPDO_IDLE: begin
        if (start) begin
          // Later writes land in the fields only; this run keeps its copy.
          snap_d = order_q;
          if (order_q == '0) begin
            en_d = '0;
            state_d = rpdo_pkg::RPDO_DONE;
          end else begin
            state_d = rpdo_pkg::RPDO_STEP;
          end
        end
      end
      rpdo_pkg::RPDO_STEP: begin
        // Highest pending value goes first; equal values share the step.
        en_d = left;
        cnt_d = '0;
        if (left == '0) begin
          state_d = rpdo_pkg::RPDO_DONE;
        end else begin
          state_d = rpdo_pkg::RPDO_WAIT;
        end
      end
      rpdo_pkg::RPDO_WAIT: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (gap_end) begin
          state_d = rpdo_pkg::RPDO_STEP;
        end
      end
      rpdo_pkg::RPDO_DONE: begin
        // Outputs stay off until reset brings the system back.
        state_d = rpdo_pkg::RPDO_DONE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state_q <= rpdo_pkg::RPDO_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      en_q <= '1;
    end else begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      snap_q <= '0;
    end else begin
      snap_q <= snap_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_out_enable = en_q;
  assign o_busy = state_q == rpdo_pkg::RPDO_STEP ||
                  state_q == rpdo_pkg::RPDO_WAIT;
  assign o_done = state_q == rpdo_pkg::RPDO_DONE;

endmodule

// *** tb/rpdo_props.sv ***
// Checker of the power-down order block, bound to its top module.
`timescale 1ns/1ps
module rpdo_props #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [20:0] i_fused_on_order,
  input wire logic i_load_fused,
  input wire logic i_power_down,
  input wire logic [20:0] o_on_order,
  input wire logic [6:0] o_out_enable,
  input wire logic o_busy,
  input wire logic o_done
);
  // ***********************************************
  // Properties
  // ***********************************************
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic map_ok;
  assign map_ok = i_paddr[1:0] == 2'h0 &&
    (i_paddr[9:2] inside {[8'h5F:8'h65], 8'h70, 8'h71});
  pready_high_a: assert property (i_psel |-> o_pready)
    else $error("pready low");
  bad_addr_err_a: assert property (i_psel && i_penable && !map_ok |->
    o_pslverr) else $error("no slave error");
  good_addr_ok_a: assert property (i_psel && i_penable && map_ok |->
    !o_pslverr) else $error("stray slave error");
  on_order_fixed_a: assert property (o_on_order == i_fused_on_order)
    else $error("power-up order altered");
  no_reenable_a: assert property ($past(i_rstn) |->
    (o_out_enable & ~$past(o_out_enable)) == 7'h00)
    else $error("output back on");
  done_sticky_a: assert property (o_done |=> o_done)
    else $error("done dropped");
  done_all_off_a: assert property (o_done |-> o_out_enable == 7'h00)
    else $error("output on after done");
  step_gap_a: assert property (o_busy && $changed(o_out_enable) |=>
    $stable(o_out_enable)[*4]) else $error("steps too close");
  move_when_run_a: assert property ($changed(o_out_enable) |->
    o_busy || o_done) else $error("enable moved while idle");
  cover property (o_done && !$past(o_busy));
  cover property (o_busy && $changed(o_out_enable));
  cover property (i_psel && i_penable && o_pslverr);
endmodule
bind rpdo_top rpdo_props #(.STEP_CYCLES(STEP_CYCLES)) i_props (.i_clk_sys,
  .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_fused_on_order, .i_load_fused, .i_power_down,
  .o_on_order, .o_out_enable, .o_busy, .o_done);

// *** tb/tb.sv ***
// Self-checking bench of the power-down order block.
`timescale 1ns/1ps
module tb;
  logic clk, rstn = 0, psel = 0, pen = 0, pwr = 0, ld = 0, pd = 0;
  logic [31:0] addr = 32'h0, wdat = 32'h0, rdat, prdata;
  logic [20:0] fused = 21'h0, on_ord;
  logic [6:0] en;
  logic rdy, err, busy, done, serr;
  int err_total = 0, n_tests = 0;
  rpdo_top i_rpdo_top (.i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
    .o_prdata(prdata), .o_pready(rdy), .o_pslverr(serr),
    .i_fused_on_order(fused), .i_load_fused(ld), .i_power_down(pd),
    .o_on_order(on_ord), .o_out_enable(en), .o_busy(busy), .o_done(done));
  // ***********************************************
  // Tasks
  // ***********************************************
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    addr <= {22'h0, idx, 2'h0};
    wdat <= d;
    @(posedge clk);
    pen <= 1;
    // Only the watchdog ends a wait for pready.
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdat = prdata;
    err = serr;
    psel <= 0;
    pen <= 0;
  endtask
  // Clears every still-on output that holds the highest pending order.
  function automatic logic [6:0] nxt(input logic [6:0] e,
                                     input logic [20:0] o);
    logic [2:0] m;
    m = 3'h0;
    for (int i = 0; i < 7; i++) if (e[i] && o[3*i+:3] > m) m = o[3*i+:3];
    for (int i = 0; i < 7; i++) if (o[3*i+:3] == m) e[i] = 0;
    return e;
  endfunction
  task automatic run_seq(input logic [20:0] o, input logic ctl);
    logic [6:0] cur;
    int last;
    cur = 7'h7F;
    last = -1;
    if (ctl) apb(1, 8'h70, 32'h1);
    else begin
      @(posedge clk);
      pd <= 1;
      @(posedge clk);
      pd <= 0;
    end
    for (int c = 0; c < 300 && !done; c++) begin
      @(posedge clk);
      #1;
      if (en !== cur) begin
        cur = nxt(cur, o);
        chk(en, cur);
        chk({busy, done}, {cur != 0, cur == 0});
        if (last >= 0) chk(c - last, rpdo_pkg::STEP_CYCLES + 1);
        last = c;
      end
    end
    @(posedge clk);
    chk({done, en}, 32'h80);
    apb(0, 8'h71, 32'h0);
    chk(rdat, 32'h2);
  endtask
  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    logic [20:0] o;
    int unsigned s;
    s = $urandom(25);
    for (int t = 0; t < 8; t++) begin
      rstn <= 0;
      repeat (12) @(posedge clk);
      rstn <= 1;
      fused <= 21'($urandom);
      apb(0, 8'(8'h5F + t % 7), 32'h0);
      chk(rdat, 32'h0);
      chk(en, 32'h7F);
      apb(0, 8'h71, 32'h0);
      chk(rdat, 32'h7F00);
      if (t % 2 == 0) begin
        @(posedge clk);
        ld <= 1;
        @(posedge clk);
        ld <= 0;
      end else begin
        apb(1, 8'h70, 32'h2);
      end
      o = fused;
      if (t == 0) o = 21'h0;
      if (t > 3) o = 21'($urandom);
      for (int i = 0; i < 7 && (t == 0 || t > 3); i++)
        apb(1, 8'(8'h5F + i), {29'h0, o[3*i+:3]});
      for (int i = 0; i < 7; i++) begin
        apb(0, 8'(8'h5F + i), 32'h0);
        chk(rdat, {29'h0, o[3*i+:3]});
      end
      apb(0, 8'h50, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rdat, 32'h0);
      chk(on_ord, fused);
      run_seq(o, t[0]);
    end
    complete_run;
  end
  initial begin
    #50000;
    err_total++;
    complete_run;
  end
endmodule
